// *** design/pmwc_pkg.sv ***
package pmwc_pkg;
    localparam logic [2:0] CLK_SEL_IRC = 3'h0;
    localparam logic [2:0] CLK_SEL_LPOSC = 3'h1;
    localparam logic [2:0] CLK_SEL_EXTPIN = 3'h2;
    localparam logic [2:0] CLK_SEL_RTC32K = 3'h3;
    localparam logic [2:0] CLK_SEL_PLL = 3'h4;
    localparam logic [1:0] MODE_SLEEP = 2'h0;
    localparam logic [1:0] MODE_DEEP_SLEEP = 2'h1;
    localparam logic [1:0] MODE_POWER_DOWN = 2'h2;
    localparam logic [1:0] MODE_DEEP_PD = 2'h3;
    localparam int IRC_FREQ_MHZ = 12;
    localparam int WAKE_SRC_W = 8;
    localparam int WAKE_PIN_INT = 0;
    localparam int WAKE_RTC_ALARM = 1;
    localparam int WAKE_UTICK = 2;
    localparam int WAKE_WDOG = 3;
    localparam int WAKE_BROWNOUT = 4;
    localparam int WAKE_USART = 5;
    localparam int WAKE_SPI = 6;
    localparam int WAKE_I2C = 7;
    localparam int CLK_GATE_W = 8;
    localparam int DS_WAKE_NS = 1000;
    localparam int PD_WAKE_NS = 10000;
    localparam int CLK_PERIOD_NS = 10;
    localparam int DS_WAKE_CYC = (DS_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PD_WAKE_CYC = (PD_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 12;
    typedef enum logic [5:0] {
        ST_RUN = 6'b00_0001,
        ST_SLEEP = 6'b00_0010,
        ST_DEEP_SLEEP = 6'b00_0100,
        ST_POWER_DOWN = 6'b00_1000,
        ST_DEEP_PD = 6'b01_0000,
        ST_WAKE = 6'b10_0000
    } pmwc_state_type;
endpackage

// *** design/pmwc_wait_counter.sv ***
`timescale 1ns/1ps
module pmwc_wait_counter
    import pmwc_pkg::*;
#(
    parameter int WIDTH = CNT_W
)(
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic load_i,
    input wire logic [WIDTH-1:0] count_i,
    output logic done_o
);
    logic [WIDTH-1:0] cnt;
    logic [WIDTH-1:0] next_cnt;
    logic running;
    logic next_running;
    logic next_done;

    always_comb
    begin
        next_cnt = cnt;
        next_running = running;
        next_done = 1'b0;
        if (load_i)
        begin
            next_cnt = count_i;
            next_running = 1'b1;
        end
        else if (running)
        begin
            if (cnt <= WIDTH'(1))
            begin
                next_running = 1'b0;
                next_done = 1'b1;
                next_cnt = '0;
            end
            else
            begin
                next_cnt = cnt - WIDTH'(1);
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cnt <= '0;
            running <= 1'b0;
            done_o <= 1'b0;
        end
        else
        begin
            cnt <= next_cnt;
            running <= next_running;
            done_o <= next_done;
        end
    end
endmodule

// *** design/pmwc_top.sv ***
`timescale 1ns/1ps
module pmwc_top
    import pmwc_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    input wire logic [2:0] clk_sel_i,
    input wire logic clk_sel_wr_i,
    input wire logic pll_en_i,
    input wire logic [1:0] mode_req_i,
    input wire logic wfi_i,
    input wire logic [CLK_GATE_W-1:0] periph_in_use_i,
    input wire logic keep_rtc32k_i,
    input wire logic keep_lposc_i,
    input wire logic keep_brownout_i,
    input wire logic [WAKE_SRC_W-1:0] wake_src_i,
    input wire logic [WAKE_SRC_W-1:0] sys_wake_en_i,
    input wire logic [WAKE_SRC_W-1:0] core_irq_en_i,
    input wire logic irq_pending_i,
    input wire logic brownout_flag_lvl_i,
    input wire logic brownout_rst_lvl_i,
    input wire logic brownout_rst_en_i,
    input wire logic brownout_flag_clr_i,
    input wire logic wdog_enable_i,
    input wire logic wdog_cfg_wr_i,
    output logic [2:0] clk_src_o,
    output logic pll_on_o,
    output logic core_clk_en_o,
    output logic [CLK_GATE_W-1:0] periph_clk_en_o,
    output logic irc_on_o,
    output logic lposc_on_o,
    output logic extpin_on_o,
    output logic rtc32k_on_o,
    output logic analog_on_o,
    output logic flash_standby_o,
    output logic flash_off_o,
    output logic brownout_on_o,
    output logic pin_hold_o,
    output logic retain_o,
    output logic main_power_o,
    output logic [1:0] mode_o,
    output logic wake_o,
    output logic brownout_flag_o,
    output logic brownout_irq_o,
    output logic chip_reset_o,
    output logic wdog_locked_o,
    output logic wdog_cfg_we_o
);
    logic rst_s1;
    logic rst_n;
    pmwc_state_type state;
    pmwc_state_type next_state;
    logic [2:0] clk_src;
    logic [2:0] next_clk_src;
    logic pll_on;
    logic next_pll_on;
    logic [1:0] mode;
    logic [1:0] next_mode;
    logic wait_load;
    logic [CNT_W-1:0] wait_count;
    logic wait_done;
    logic wake_hit;
    logic next_core_clk_en;
    logic [CLK_GATE_W-1:0] next_periph_clk_en;
    logic next_irc_on;
    logic next_lposc_on;
    logic next_extpin_on;
    logic next_rtc32k_on;
    logic next_analog_on;
    logic next_flash_standby;
    logic next_flash_off;
    logic next_brownout_on;
    logic next_pin_hold;
    logic next_retain;
    logic next_main_power;
    logic next_wake;
    logic next_brownout_flag;
    logic next_brownout_irq;
    logic next_chip_reset;
    logic next_wdog_locked;
    logic next_wdog_cfg_we;

    function automatic logic [CLK_GATE_W-1:0] gate_all(input logic on);
        gate_all = on ? '1 : '0;
    endfunction

    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            rst_s1 <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_s1 <= 1'b1;
            rst_n <= rst_s1;
        end
    end

    pmwc_wait_counter #(
        .WIDTH(CNT_W)
    ) u_wait (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n),
        .load_i(wait_load),
        .count_i(wait_count),
        .done_o(wait_done)
    );

    // qualified wake: both enables must be set
    assign wake_hit = |(wake_src_i & sys_wake_en_i & core_irq_en_i);

    // clock source and pll control
    always_comb
    begin
        next_clk_src = clk_src;
        next_pll_on = pll_en_i;
        if (clk_sel_wr_i && clk_sel_i <= CLK_SEL_PLL)
        begin
            next_clk_src = clk_sel_i;
        end
    end

    // mode sequencer
    always_comb
    begin
        next_state = state;
        next_mode = mode;
        wait_load = 1'b0;
        wait_count = '0;
        next_wake = 1'b0;
        case (state)
            ST_RUN:
            begin
                if (wfi_i)
                begin
                    next_mode = mode_req_i;
                    case (mode_req_i)
                        MODE_SLEEP: next_state = ST_SLEEP;
                        MODE_DEEP_SLEEP: next_state = ST_DEEP_SLEEP;
                        MODE_POWER_DOWN: next_state = ST_POWER_DOWN;
                        default: next_state = ST_DEEP_PD;
                    endcase
                end
            end
            ST_SLEEP:
            begin
                if (irq_pending_i)
                begin
                    next_state = ST_RUN;
                    next_wake = 1'b1;
                end
            end
            ST_DEEP_SLEEP:
            begin
                if (wake_hit)
                begin
                    wait_load = 1'b1;
                    wait_count = CNT_W'(DS_WAKE_CYC);
                    next_state = ST_WAKE;
                end
            end
            ST_POWER_DOWN:
            begin
                if (wake_hit)
                begin
                    wait_load = 1'b1;
                    wait_count = CNT_W'(PD_WAKE_CYC);
                    next_state = ST_WAKE;
                end
            end
            ST_DEEP_PD:
            begin
                // only the rtc alarm; the reset pin acts through arst_n_i
                if (wake_src_i[WAKE_RTC_ALARM])
                begin
                    next_state = ST_RUN;
                    next_wake = 1'b1;
                end
            end
            ST_WAKE:
            begin
                if (wait_done)
                begin
                    next_state = ST_RUN;
                    next_wake = 1'b1;
                end
            end
            default: next_state = ST_RUN;
        endcase
    end

    // gating outputs from next state
    always_comb
    begin
        next_core_clk_en = 1'b1;
        next_periph_clk_en = gate_all(1'b1);
        next_irc_on = 1'b1;
        next_lposc_on = 1'b1;
        next_extpin_on = (next_clk_src == CLK_SEL_EXTPIN);
        next_rtc32k_on = 1'b1;
        next_analog_on = 1'b1;
        next_flash_standby = 1'b0;
        next_flash_off = 1'b0;
        next_brownout_on = 1'b1;
        next_pin_hold = 1'b0;
        next_retain = 1'b0;
        next_main_power = 1'b1;
        case (next_state)
            ST_SLEEP:
            begin
                next_core_clk_en = 1'b0;
                next_periph_clk_en = periph_in_use_i;
                next_pin_hold = 1'b1;
                next_retain = 1'b1;
            end
            ST_DEEP_SLEEP, ST_WAKE:
            begin
                next_core_clk_en = 1'b0;
                next_periph_clk_en = gate_all(1'b0);
                next_irc_on = 1'b0;
                next_extpin_on = 1'b0;
                next_lposc_on = keep_lposc_i;
                next_rtc32k_on = keep_rtc32k_i;
                next_analog_on = 1'b0;
                next_brownout_on = keep_brownout_i;
                next_flash_standby = (next_mode == MODE_DEEP_SLEEP);
                next_flash_off = (next_mode == MODE_POWER_DOWN);
                next_pin_hold = 1'b1;
                next_retain = 1'b1;
            end
            ST_POWER_DOWN:
            begin
                next_core_clk_en = 1'b0;
                next_periph_clk_en = gate_all(1'b0);
                next_irc_on = 1'b0;
                next_extpin_on = 1'b0;
                next_lposc_on = keep_lposc_i;
                next_rtc32k_on = keep_rtc32k_i;
                next_analog_on = 1'b0;
                next_flash_off = 1'b1;
                next_brownout_on = keep_brownout_i;
                next_pin_hold = 1'b1;
                next_retain = 1'b1;
            end
            ST_DEEP_PD:
            begin
                next_core_clk_en = 1'b0;
                next_periph_clk_en = gate_all(1'b0);
                next_irc_on = 1'b0;
                next_lposc_on = 1'b0;
                next_extpin_on = 1'b0;
                next_rtc32k_on = 1'b1;
                next_analog_on = 1'b0;
                next_flash_off = 1'b1;
                next_brownout_on = 1'b0;
                next_main_power = 1'b0;
            end
            default:
            begin
                next_core_clk_en = 1'b1;
            end
        endcase
    end

    // brownout and watchdog lock
    always_comb
    begin
        next_brownout_flag = brownout_flag_o;
        if (brownout_flag_clr_i)
        begin
            next_brownout_flag = 1'b0;
        end
        if (brownout_flag_lvl_i || brownout_rst_lvl_i)
        begin
            next_brownout_flag = 1'b1;
        end
        next_brownout_irq = next_brownout_flag;
        next_chip_reset = brownout_rst_lvl_i && brownout_rst_en_i;
        next_wdog_locked = wdog_locked_o | wdog_enable_i;
        next_wdog_cfg_we = wdog_cfg_wr_i && !wdog_locked_o;
    end

    always_ff @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= ST_RUN;
            mode <= MODE_SLEEP;
            clk_src <= CLK_SEL_IRC;
            pll_on <= 1'b0;
            clk_src_o <= CLK_SEL_IRC;
            pll_on_o <= 1'b0;
            core_clk_en_o <= 1'b1;
            periph_clk_en_o <= '1;
            irc_on_o <= 1'b1;
            lposc_on_o <= 1'b1;
            extpin_on_o <= 1'b0;
            rtc32k_on_o <= 1'b1;
            analog_on_o <= 1'b1;
            flash_standby_o <= 1'b0;
            flash_off_o <= 1'b0;
            brownout_on_o <= 1'b1;
            pin_hold_o <= 1'b0;
            retain_o <= 1'b0;
            main_power_o <= 1'b1;
            mode_o <= MODE_SLEEP;
            wake_o <= 1'b0;
            brownout_flag_o <= 1'b0;
            brownout_irq_o <= 1'b0;
            chip_reset_o <= 1'b0;
            wdog_locked_o <= 1'b0;
            wdog_cfg_we_o <= 1'b0;
        end
        else
        begin
            state <= next_state;
            mode <= next_mode;
            clk_src <= next_clk_src;
            pll_on <= next_pll_on;
            clk_src_o <= next_clk_src;
            pll_on_o <= next_pll_on;
            core_clk_en_o <= next_core_clk_en;
            periph_clk_en_o <= next_periph_clk_en;
            irc_on_o <= next_irc_on | (next_clk_src == CLK_SEL_IRC &&
                next_state == ST_RUN);
            lposc_on_o <= next_lposc_on;
            extpin_on_o <= next_extpin_on;
            rtc32k_on_o <= next_rtc32k_on;
            analog_on_o <= next_analog_on;
            flash_standby_o <= next_flash_standby;
            flash_off_o <= next_flash_off;
            brownout_on_o <= next_brownout_on;
            pin_hold_o <= next_pin_hold;
            retain_o <= next_retain;
            main_power_o <= next_main_power;
            mode_o <= next_mode;
            wake_o <= next_wake;
            brownout_flag_o <= next_brownout_flag;
            brownout_irq_o <= next_brownout_irq;
            chip_reset_o <= next_chip_reset;
            wdog_locked_o <= next_wdog_locked;
            wdog_cfg_we_o <= next_wdog_cfg_we;
        end
    end
endmodule

// *** bench/pmwc_checker.sv ***
`timescale 1ns/1ps
module pmwc_checker
    import pmwc_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    input wire logic [2:0] clk_sel_i,
    input wire logic clk_sel_wr_i,
    input wire logic pll_en_i,
    input wire logic [1:0] mode_req_i,
    input wire logic wfi_i,
    input wire logic [CLK_GATE_W-1:0] periph_in_use_i,
    input wire logic [WAKE_SRC_W-1:0] wake_src_i,
    input wire logic [WAKE_SRC_W-1:0] sys_wake_en_i,
    input wire logic [WAKE_SRC_W-1:0] core_irq_en_i,
    input wire logic irq_pending_i,
    input wire logic brownout_flag_lvl_i,
    input wire logic wdog_cfg_wr_i,
    input wire logic [2:0] clk_src_o,
    input wire logic pll_on_o,
    input wire logic core_clk_en_o,
    input wire logic [CLK_GATE_W-1:0] periph_clk_en_o,
    input wire logic analog_on_o,
    input wire logic flash_standby_o,
    input wire logic pin_hold_o,
    input wire logic [1:0] mode_o,
    input wire logic wake_o,
    input wire logic brownout_flag_o,
    input wire logic brownout_irq_o,
    input wire logic wdog_locked_o,
    input wire logic wdog_cfg_we_o
);
    wire logic [WAKE_SRC_W-1:0] qual = wake_src_i & sys_wake_en_i
        & core_irq_en_i;
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!arst_n_i);
    chk_reset_rc_src:
        assert property ($rose(arst_n_i) |-> clk_src_o == CLK_SEL_IRC)
        else $error("clock source not rc after reset");
    chk_clk_sel_load:
        assert property (clk_sel_wr_i && clk_sel_i <= CLK_SEL_PLL
            |=> clk_src_o == $past(clk_sel_i))
        else $error("clock source not loaded");
    chk_pll_follow:
        assert property ($changed(pll_en_i) |=> pll_on_o == $past(pll_en_i))
        else $error("pll enable not followed");
    chk_sleep_gates:
        assert property (wfi_i && core_clk_en_o && mode_req_i == MODE_SLEEP
            |=> !core_clk_en_o && pin_hold_o
            && periph_clk_en_o == $past(periph_in_use_i))
        else $error("sleep gating wrong");
    chk_sleep_resume:
        assert property (mode_o == MODE_SLEEP && !core_clk_en_o
            && irq_pending_i |-> ##[1:2] wake_o)
        else $error("sleep not left on interrupt");
    chk_deep_gates:
        assert property (wfi_i && core_clk_en_o
            && mode_req_i == MODE_DEEP_SLEEP |=> flash_standby_o
            && !analog_on_o && periph_clk_en_o == '0)
        else $error("deep sleep gating wrong");
    chk_unqual_no_wake:
        assert property ((mode_o == MODE_DEEP_SLEEP
            || mode_o == MODE_POWER_DOWN) && !core_clk_en_o
            && qual == '0 |=> !wake_o)
        else $error("wake without both enables");
    chk_dpd_rtc_wake:
        assert property (mode_o == MODE_DEEP_PD && !core_clk_en_o
            && wake_src_i[WAKE_RTC_ALARM] |-> ##[1:2] wake_o)
        else $error("deep power-down not left on alarm");
    chk_bo_flag_set:
        assert property (brownout_flag_lvl_i
            |=> brownout_flag_o && brownout_irq_o)
        else $error("brownout flag not set");
    chk_wdog_cfg_lock:
        assert property (wdog_locked_o && wdog_cfg_wr_i |=> !wdog_cfg_we_o)
        else $error("locked watchdog config written");
endmodule
bind pmwc_top pmwc_checker i_chk (.*);

// *** bench/pmwc_wake_model.sv ***
`timescale 1ns/1ps
module pmwc_wake_model
    import pmwc_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic [7:0] fire_i,
    input wire logic [7:0] dly_i,
    input wire logic wake_i,
    output logic [WAKE_SRC_W-1:0] src_o,
    output logic irq_o
);
    logic [7:0] pend;
    logic [7:0] cnt;
    initial
    begin
        src_o = '0;
        irq_o = 1'b0;
        pend = '0;
        cnt = '0;
    end
    // serial sources act as slaves: they raise a request after dly_i
    always @(posedge clk_sys_i)
    begin
        if (fire_i != 8'h00)
        begin
            pend <= fire_i;
            cnt <= dly_i;
            src_o <= '0;
            irq_o <= 1'b0;
        end
        else if (wake_i)
        begin
            pend <= '0;
            src_o <= '0;
            irq_o <= 1'b0;
        end
        else if (pend != 8'h00 && cnt != 8'h00)
            cnt <= cnt - 8'h01;
        else if (pend != 8'h00)
        begin
            src_o <= pend;
            irq_o <= 1'b1;
        end
    end
endmodule

// *** bench/test_power_mode_wake_controller.sv ***
`timescale 1ns/1ps
module test_power_mode_wake_controller;
    import pmwc_pkg::*;
    logic clk_sys_i, arst_n_i, clk_sel_wr_i, pll_en_i, wfi_i, wake_o;
    logic keep_rtc32k_i, keep_lposc_i, keep_brownout_i, irq_pending_i;
    logic brownout_flag_lvl_i, brownout_rst_lvl_i, brownout_rst_en_i;
    logic brownout_flag_clr_i, wdog_enable_i, wdog_cfg_wr_i;
    logic [2:0] clk_sel_i, clk_src_o;
    logic [1:0] mode_req_i, mode_o;
    logic [7:0] periph_in_use_i, wake_src_i, sys_wake_en_i, core_irq_en_i;
    logic pll_on_o, core_clk_en_o, irc_on_o, lposc_on_o, extpin_on_o;
    logic rtc32k_on_o, analog_on_o, flash_standby_o, flash_off_o;
    logic brownout_on_o, pin_hold_o, retain_o, main_power_o;
    logic brownout_flag_o, brownout_irq_o, chip_reset_o, wdog_locked_o;
    logic wdog_cfg_we_o;
    logic [7:0] periph_clk_en_o, fire, dly;
    int miscompares, checked, cycles, lat, cyc;
    pmwc_top i_dut (.*);
    pmwc_wake_model i_far (.clk_sys_i(clk_sys_i), .fire_i(fire),
        .dly_i(dly), .wake_i(wake_o), .src_o(wake_src_i),
        .irq_o(irq_pending_i));
    initial
    begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end
    task automatic summarize();
        if (miscompares == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    always @(posedge clk_sys_i)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            miscompares++;
            summarize();
        end
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic enter(input logic [1:0] m);
        mode_req_i = m;
        wfi_i = 1'b1;
        tick(1);
        wfi_i = 1'b0;
        tick(1);
    endtask
    // lat ends at lim when no wake pulse is seen
    task automatic wake(input logic [7:0] src, input logic [7:0] d,
        input int lim);
        fire = src;
        dly = d;
        tick(1);
        fire = 8'h00;
        lat = 1;
        while (wake_o !== 1'b1 && lat < lim)
        begin
            tick(1);
            lat++;
        end
        tick(1);
    endtask
    initial
    begin
        {arst_n_i, clk_sel_wr_i, pll_en_i, wfi_i, clk_sel_i, mode_req_i} = '0;
        {keep_lposc_i, brownout_flag_lvl_i, brownout_rst_lvl_i} = '0;
        {brownout_rst_en_i, brownout_flag_clr_i, wdog_enable_i} = '0;
        {wdog_cfg_wr_i, fire, dly, periph_in_use_i} = '0;
        {keep_rtc32k_i, keep_brownout_i} = 2'b11;
        sys_wake_en_i = 8'hFF;
        core_irq_en_i = 8'hFF;
        {miscompares, checked, cycles} = '0;
        tick(12);
        arst_n_i = 1'b1;
        tick(3);
        check(clk_src_o, CLK_SEL_IRC);
        check(irc_on_o, 1'b1);
        for (int c = 7; c >= 0; c--)
        begin
            clk_sel_i = 3'(c);
            clk_sel_wr_i = 1'b1;
            tick(1);
            clk_sel_wr_i = 1'b0;
            tick(1);
            check(clk_src_o, (c > 4) ? CLK_SEL_IRC : 3'(c));
            check(extpin_on_o, c == 2);
        end
        pll_en_i = 1'b1;
        tick(2);
        check(pll_on_o, 1'b1);
        pll_en_i = 1'b0;
        tick(2);
        check(pll_on_o, 1'b0);
        periph_in_use_i = 8'h5A;
        enter(MODE_SLEEP);
        check(core_clk_en_o, 1'b0);
        check(periph_clk_en_o, 8'h5A);
        check(pin_hold_o, 1'b1);
        check(retain_o, 1'b1);
        check(mode_o, MODE_SLEEP);
        enter(MODE_DEEP_PD);
        check(mode_o, MODE_SLEEP);
        wake(8'h20, 8'd5, 50);
        check(lat >= 6 && lat <= 9, 1'b1);
        check(core_clk_en_o, 1'b1);
        enter(MODE_DEEP_SLEEP);
        sys_wake_en_i = 8'h00;
        wake(8'h01, 8'd0, 200);
        check(lat == 200, 1'b1);
        sys_wake_en_i = 8'hFF;
        core_irq_en_i = 8'h00;
        wake(8'h01, 8'd0, 200);
        check(lat == 200, 1'b1);
        core_irq_en_i = 8'hFF;
        wake(8'h01, 8'd0, 2000);
        check(lat < 2000, 1'b1);
        for (int m = 1; m <= 2; m++)
            for (int b = 0; b < 8; b++)
            begin
                enter(2'(m));
                check(m == 2 ? flash_off_o : flash_standby_o, 1'b1);
                check(analog_on_o, 1'b0);
                check({rtc32k_on_o, lposc_on_o}, 2'b10);
                check(brownout_on_o, 1'b1);
                check({pin_hold_o, retain_o}, 2'b11);
                wake(8'h01 << b, 8'(b), 2000);
                cyc = (m == 1) ? DS_WAKE_CYC : PD_WAKE_CYC;
                check(lat >= cyc + b && lat <= cyc + b + 6, 1'b1);
            end
        enter(MODE_DEEP_PD);
        check(main_power_o, 1'b0);
        wake(8'hFD, 8'd0, 100);
        check(lat == 100, 1'b1);
        wake(8'h02, 8'd0, 50);
        check(lat <= 4, 1'b1);
        {brownout_flag_lvl_i, brownout_flag_clr_i} = 2'b11;
        tick(1);
        {brownout_flag_lvl_i, brownout_flag_clr_i} = 2'b00;
        tick(3);
        check({brownout_flag_o, brownout_irq_o}, 2'b11);
        brownout_flag_clr_i = 1'b1;
        tick(1);
        brownout_flag_clr_i = 1'b0;
        tick(1);
        check(brownout_flag_o, 1'b0);
        {brownout_rst_en_i, brownout_rst_lvl_i} = 2'b11;
        tick(2);
        check({chip_reset_o, brownout_irq_o}, 2'b11);
        brownout_rst_lvl_i = 1'b0;
        tick(2);
        check(chip_reset_o, 1'b0);
        wdog_cfg_wr_i = 1'b1;
        tick(1);
        wdog_cfg_wr_i = 1'b0;
        check(wdog_cfg_we_o, 1'b1);
        wdog_enable_i = 1'b1;
        tick(1);
        wdog_enable_i = 1'b0;
        wdog_cfg_wr_i = 1'b1;
        tick(1);
        wdog_cfg_wr_i = 1'b0;
        check({wdog_locked_o, wdog_cfg_we_o}, 2'b10);
        arst_n_i = 1'b0;
        tick(2);
        arst_n_i = 1'b1;
        tick(3);
        check(wdog_locked_o, 1'b0);
        summarize();
    end
endmodule
